// *** core/qrcfg_regs.sv ***
module qrcfg_regs
    import qrcfg_pkg::*;
#(
    parameter logic [7:0] DEVICE_IDENTITY = 8'h5a  // arbitrary value
)(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // three-wire serial port
    input  wire logic       sclk,
    input  wire logic       port_select_n,
    input  wire logic       sdio_in,
    output logic            sdio_out,
    output logic            sdio_oe_n,
    // external power-down pin
    input  wire logic       pdwn_pin,
    // per-channel controls, bit 0 is channel a
    output logic [3:0]      chan_powerdown,
    output logic [3:0]      chan_standby,
    output logic [3:0]      chan_shuffle_en,
    // output port enables
    output logic            out_port_en_ab,
    output logic            out_port_en_cd,
    // converter clock enable
    output logic            conv_clk_en
);
    import qrcfg_pkg::*;

    logic        wr_stb;
    logic [12:0] acc_addr;
    logic [7:0]  wr_data, rd_data;

    // port configuration, channel select and commit flag
    logic        lsb_r, lsb_nxt, srst_r, srst_nxt;
    logic [7:0]  csel_r, csel_nxt;
    logic        commit_r, commit_nxt;
    // shadow (written) and active (applied) copies
    logic [1:0]  pm_sh_r [NUM_CH], pm_sh_nxt [NUM_CH];
    logic [1:0]  pm_ac_r [NUM_CH], pm_ac_nxt [NUM_CH];
    logic [1:0]  sf_sh_r [NUM_CH], sf_sh_nxt [NUM_CH];
    logic [1:0]  sf_ac_r [NUM_CH], sf_ac_nxt [NUM_CH];
    logic        pinfn_sh_r, pinfn_sh_nxt, pinfn_ac_r, pinfn_ac_nxt;
    logic [5:0]  cdiv_sh_r, cdiv_sh_nxt, cdiv_ac_r, cdiv_ac_nxt;
    // divider, pin sync and read channel
    logic [2:0]  div_cnt_r, div_cnt_nxt;
    logic [6:0]  dly_r, dly_nxt;
    logic        conv_en_r, conv_en_nxt;
    logic        pd_s1_r, pd_s2_r;
    logic [1:0]  rd_ch;
    logic        div_pulse;
    logic [7:0]  taps;

    qrcfg_serial u_serial (
        .clk           (clk),
        .rst_n         (rst_n),
        .sclk          (sclk),
        .port_select_n (port_select_n),
        .sdio_in       (sdio_in),
        .sdio_out      (sdio_out),
        .sdio_oe_n     (sdio_oe_n),
        .lsb_first     (lsb_r),
        .wr_stb        (wr_stb),
        .acc_addr      (acc_addr),
        .wr_data       (wr_data),
        .rd_data       (rd_data)
    );

    // read channel: single selection picks it, several pick a
    always_comb begin
        rd_ch = 2'h0;
        unique case (csel_r[3:0])
            4'h2:    rd_ch = 2'h1;
            4'h4:    rd_ch = 2'h2;
            4'h8:    rd_ch = 2'h3;
            default: rd_ch = 2'h0;
        endcase
    end

    // read mux; shadow copies are what software sees
    always_comb begin
        rd_data = 8'h00;
        unique case (acc_addr)
            OFS_PORT_CONFIG:
                rd_data = {1'b0, lsb_r, srst_r, 2'h3, srst_r, lsb_r, 1'b0};
            OFS_DEVICE_IDENTITY: rd_data = DEVICE_IDENTITY;
            OFS_CHANNEL_SELECT:  rd_data = {csel_r[7:6], 2'h0, csel_r[3:0]};
            OFS_POWER_MODES:
                rd_data = {2'h0, pinfn_sh_r, 3'h0, pm_sh_r[rd_ch]};
            OFS_CLOCK_DIVIDER:   rd_data = {2'h0, cdiv_sh_r};
            OFS_SHUFFLE_CONTROL: rd_data = {6'h00, sf_sh_r[rd_ch]};
            OFS_SHADOW_COMMIT:   rd_data = {7'h00, commit_r};
            default:             rd_data = 8'h00;
        endcase
    end

    // register state: writes, soft reset, commit
    always_comb begin
        lsb_nxt      = lsb_r;
        srst_nxt     = 1'b0;       // soft reset clears itself
        csel_nxt     = csel_r;
        commit_nxt   = commit_r;
        pinfn_sh_nxt = pinfn_sh_r;
        pinfn_ac_nxt = pinfn_ac_r;
        cdiv_sh_nxt  = cdiv_sh_r;
        cdiv_ac_nxt  = cdiv_ac_r;
        for (int i = 0; i < NUM_CH; i++) begin
            pm_sh_nxt[i] = pm_sh_r[i];
            pm_ac_nxt[i] = pm_ac_r[i];
            sf_sh_nxt[i] = sf_sh_r[i];
            sf_ac_nxt[i] = sf_ac_r[i];
        end
        if (commit_r) begin
            commit_nxt   = 1'b0;
            pinfn_ac_nxt = pinfn_sh_r;
            cdiv_ac_nxt  = cdiv_sh_r;
            for (int i = 0; i < NUM_CH; i++) begin
                pm_ac_nxt[i] = pm_sh_r[i];
                sf_ac_nxt[i] = sf_sh_r[i];
            end
        end
        if (srst_r) begin
            // soft reset reloads defaults but keeps the shift order
            csel_nxt     = RST_CHANNEL_SELECT;
            commit_nxt   = RST_SHADOW_COMMIT[COMMIT_BIT];
            pinfn_sh_nxt = RST_POWER_MODES[PM_PIN_FN];
            pinfn_ac_nxt = RST_POWER_MODES[PM_PIN_FN];
            cdiv_sh_nxt  = RST_CLOCK_DIVIDER[5:0];
            cdiv_ac_nxt  = RST_CLOCK_DIVIDER[5:0];
            for (int i = 0; i < NUM_CH; i++) begin
                pm_sh_nxt[i] = RST_POWER_MODES[1:0];
                pm_ac_nxt[i] = RST_POWER_MODES[1:0];
                sf_sh_nxt[i] = RST_SHUFFLE_CONTROL[1:0];
                sf_ac_nxt[i] = RST_SHUFFLE_CONTROL[1:0];
            end
        end else if (wr_stb) begin
            unique case (acc_addr)
                OFS_PORT_CONFIG: begin
                    if (csel_r[3:0] == 4'hf) begin
                        // either nibble copy sets the function
                        lsb_nxt  = wr_data[PC_LSB_HI] | wr_data[PC_LSB_LO];
                        srst_nxt = wr_data[PC_SRST_HI] | wr_data[PC_SRST_LO];
                    end
                end
                OFS_CHANNEL_SELECT:
                    csel_nxt = {wr_data[7:6], 2'h0, wr_data[3:0]};
                OFS_POWER_MODES: begin
                    pinfn_sh_nxt = wr_data[PM_PIN_FN];
                    for (int i = 0; i < NUM_CH; i++)
                        if (csel_r[i])
                            pm_sh_nxt[i] = wr_data[1:0];
                end
                OFS_CLOCK_DIVIDER:
                    cdiv_sh_nxt = wr_data[5:0];
                OFS_SHUFFLE_CONTROL:
                    for (int i = 0; i < NUM_CH; i++)
                        if (csel_r[i])
                            sf_sh_nxt[i] = wr_data[1:0];
                OFS_SHADOW_COMMIT:
                    // a new commit wins over the self-clear
                    commit_nxt = commit_nxt | wr_data[COMMIT_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lsb_r      <= RST_PORT_CONFIG[PC_LSB_LO];
            srst_r     <= RST_PORT_CONFIG[PC_SRST_LO];
            csel_r     <= RST_CHANNEL_SELECT;
            commit_r   <= RST_SHADOW_COMMIT[COMMIT_BIT];
            pinfn_sh_r <= RST_POWER_MODES[PM_PIN_FN];
            pinfn_ac_r <= RST_POWER_MODES[PM_PIN_FN];
            cdiv_sh_r  <= RST_CLOCK_DIVIDER[5:0];
            cdiv_ac_r  <= RST_CLOCK_DIVIDER[5:0];
            for (int i = 0; i < NUM_CH; i++) begin
                pm_sh_r[i] <= RST_POWER_MODES[1:0];
                pm_ac_r[i] <= RST_POWER_MODES[1:0];
                sf_sh_r[i] <= RST_SHUFFLE_CONTROL[1:0];
                sf_ac_r[i] <= RST_SHUFFLE_CONTROL[1:0];
            end
        end else begin
            lsb_r      <= lsb_nxt;
            srst_r     <= srst_nxt;
            csel_r     <= csel_nxt;
            commit_r   <= commit_nxt;
            pinfn_sh_r <= pinfn_sh_nxt;
            pinfn_ac_r <= pinfn_ac_nxt;
            cdiv_sh_r  <= cdiv_sh_nxt;
            cdiv_ac_r  <= cdiv_ac_nxt;
            for (int i = 0; i < NUM_CH; i++) begin
                pm_sh_r[i] <= pm_sh_nxt[i];
                pm_ac_r[i] <= pm_ac_nxt[i];
                sf_sh_r[i] <= sf_sh_nxt[i];
                sf_ac_r[i] <= sf_ac_nxt[i];
            end
        end
    end

    // power-down pin is asynchronous: two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_s1_r <= 1'b0;
            pd_s2_r <= 1'b0;
        end else begin
            pd_s1_r <= pdwn_pin;
            pd_s2_r <= pd_s1_r;
        end
    end

    // effective power state per channel; pin overrides the code
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            chan_powerdown[i] = pd_s2_r ? ~pinfn_ac_r
                                        : (pm_ac_r[i] == PM_FULL);
            chan_standby[i]   = pd_s2_r ? pinfn_ac_r
                                        : (pm_ac_r[i] == PM_STBY);
            chan_shuffle_en[i] = (sf_ac_r[i] == SHUF_ON);
        end
    end

    assign out_port_en_ab = csel_r[CS_OUT_AB];
    assign out_port_en_cd = csel_r[CS_OUT_CD];

    // divider: pulse every ratio+1 cycles, then tapped delay for phase
    assign div_pulse = (div_cnt_r >= cdiv_ac_r[2:0]);
    assign taps      = {dly_r, div_pulse};

    always_comb begin
        div_cnt_nxt = div_pulse ? 3'h0 : div_cnt_r + 3'h1;
        dly_nxt     = {dly_r[5:0], div_pulse};
        conv_en_nxt = taps[cdiv_ac_r[5:CD_PHASE_LO]];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 3'h0;
            dly_r     <= 7'h00;
            conv_en_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            dly_r     <= dly_nxt;
            conv_en_r <= conv_en_nxt;
        end
    end

    assign conv_clk_en = conv_en_r;
endmodule

// *** pkg/qrcfg_pkg.sv ***
package qrcfg_pkg;
    // serial framing
    localparam int          ADDR_W     = 13;
    localparam int          INS_RW     = 15;
    localparam int          INS_LEN_HI = 14;
    localparam int          INS_LEN_LO = 13;
    localparam logic [1:0]  LEN_STREAM = 2'h3;

    // register offsets
    localparam logic [12:0] OFS_PORT_CONFIG     = 13'h0000;
    localparam logic [12:0] OFS_DEVICE_IDENTITY = 13'h0001;
    localparam logic [12:0] OFS_CHANNEL_SELECT  = 13'h0005;
    localparam logic [12:0] OFS_POWER_MODES     = 13'h0008;
    localparam logic [12:0] OFS_CLOCK_DIVIDER   = 13'h000b;
    localparam logic [12:0] OFS_SHUFFLE_CONTROL = 13'h000c;
    localparam logic [12:0] OFS_SHADOW_COMMIT   = 13'h00ff;

    // reset values
    localparam logic [7:0]  RST_PORT_CONFIG     = 8'h18;
    localparam logic [7:0]  RST_CHANNEL_SELECT  = 8'hcf;
    localparam logic [7:0]  RST_POWER_MODES     = 8'h00;
    localparam logic [7:0]  RST_CLOCK_DIVIDER   = 8'h00;
    localparam logic [7:0]  RST_SHUFFLE_CONTROL = 8'h01;
    localparam logic [7:0]  RST_SHADOW_COMMIT   = 8'h00;

    // field positions and channel count
    localparam int          PC_LSB_HI    = 6;
    localparam int          PC_SRST_HI   = 5;
    localparam int          PC_SRST_LO   = 2;
    localparam int          PC_LSB_LO    = 1;
    localparam int          CS_OUT_CD    = 7;
    localparam int          CS_OUT_AB    = 6;
    localparam int          PM_PIN_FN    = 5;
    localparam int          CD_PHASE_LO  = 3;
    localparam int          COMMIT_BIT   = 0;
    localparam int          NUM_CH       = 4;

    // power mode and shuffle codes
    localparam logic [1:0]  PM_NORMAL = 2'h0;
    localparam logic [1:0]  PM_FULL   = 2'h1;
    localparam logic [1:0]  PM_STBY   = 2'h2;
    localparam logic [1:0]  SHUF_ON   = 2'h1;
endpackage

// *** core/qrcfg_serial.sv ***
module qrcfg_serial
    import qrcfg_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // three-wire serial pins
    input  wire logic                 sclk,
    input  wire logic                 port_select_n,
    input  wire logic                 sdio_in,
    output logic                      sdio_out,
    output logic                      sdio_oe_n,
    // register side
    input  wire logic                 lsb_first,
    output logic                      wr_stb,
    output logic [qrcfg_pkg::ADDR_W-1:0] acc_addr,
    output logic [7:0]                wr_data,
    input  wire logic [7:0]           rd_data
);
    typedef enum logic [1:0] {SER_INSTR, SER_DATA, SER_DONE} qrcfg_ser_e;

    logic        sclk_s1_r, sclk_s2_r, sclk_d_r;
    logic        cs_s1_r, cs_s2_r, din_s1_r, din_s2_r;
    qrcfg_ser_e  state_r, state_nxt;
    logic [15:0] sh_r, sh_nxt, shin;
    logic [3:0]  bitcnt_r, bitcnt_nxt;
    logic        rw_r, rw_nxt, step_r, step_nxt, load_r, load_nxt;
    logic [1:0]  len_r, len_nxt, bytecnt_r, bytecnt_nxt;
    logic [12:0] addr_r, addr_nxt;
    logic [7:0]  tx_r, tx_nxt, wdata_r, wdata_nxt;
    logic        dout_r, dout_nxt, oe_n_r, oe_n_nxt, wr_r, wr_nxt;
    logic        rise, fall;

    // pins come from the host's clock domain: two flops first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d_r  <= 1'b0;
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            din_s1_r  <= 1'b0;
            din_s2_r  <= 1'b0;
        end else begin
            sclk_s1_r <= sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r  <= sclk_s2_r;
            cs_s1_r   <= port_select_n;
            cs_s2_r   <= cs_s1_r;
            din_s1_r  <= sdio_in;
            din_s2_r  <= din_s1_r;
        end
    end

    assign rise = sclk_s2_r & ~sclk_d_r;
    assign fall = ~sclk_s2_r & sclk_d_r;

    // frame sequencer; sclk must be well below clk/8 so steps never overlap
    always_comb begin
        state_nxt   = state_r;
        sh_nxt      = sh_r;
        bitcnt_nxt  = bitcnt_r;
        rw_nxt      = rw_r;
        len_nxt     = len_r;
        bytecnt_nxt = bytecnt_r;
        addr_nxt    = addr_r;
        tx_nxt      = tx_r;
        wdata_nxt   = wdata_r;
        dout_nxt    = dout_r;
        oe_n_nxt    = oe_n_r;
        wr_nxt      = 1'b0;
        step_nxt    = 1'b0;
        load_nxt    = 1'b0;
        shin = lsb_first ? {din_s2_r, sh_r[15:1]} : {sh_r[14:0], din_s2_r};
        if (cs_s2_r) begin
            state_nxt  = SER_INSTR;   // frame ends with the select pin
            bitcnt_nxt = 4'h0;
            oe_n_nxt   = 1'b1;
        end else begin
            if (load_r)
                tx_nxt = rd_data;
            if (step_r) begin
                // msb-first walks down, lsb-first walks up
                addr_nxt = lsb_first ? addr_r + 13'h0001 : addr_r - 13'h0001;
                load_nxt = rw_r & (state_r == SER_DATA);
            end
            if (rise && state_r != SER_DONE) begin
                sh_nxt     = shin;
                bitcnt_nxt = bitcnt_r + 4'h1;
                if (state_r == SER_INSTR && bitcnt_r == 4'hf) begin
                    rw_nxt      = shin[INS_RW];
                    len_nxt     = shin[INS_LEN_HI:INS_LEN_LO];
                    addr_nxt    = shin[ADDR_W-1:0];
                    bytecnt_nxt = 2'h0;
                    bitcnt_nxt  = 4'h0;
                    state_nxt   = SER_DATA;
                    load_nxt    = shin[INS_RW];
                end else if (state_r == SER_DATA && bitcnt_r == 4'h7) begin
                    bitcnt_nxt  = 4'h0;
                    wr_nxt      = ~rw_r;
                    wdata_nxt   = lsb_first ? shin[15:8] : shin[7:0];
                    step_nxt    = 1'b1;
                    bytecnt_nxt = bytecnt_r + 2'h1;
                    if (len_r != LEN_STREAM && bytecnt_r == len_r) begin
                        state_nxt = SER_DONE;
                        oe_n_nxt  = 1'b1;
                    end
                end
            end
            // read data changes on the falling edge, host samples on rising
            if (fall && state_r == SER_DATA && rw_r) begin
                dout_nxt = lsb_first ? tx_r[0] : tx_r[7];
                tx_nxt   = lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
                oe_n_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= SER_INSTR;
            sh_r      <= 16'h0000;
            bitcnt_r  <= 4'h0;
            rw_r      <= 1'b0;
            len_r     <= 2'h0;
            bytecnt_r <= 2'h0;
            addr_r    <= 13'h0000;
            tx_r      <= 8'h00;
            wdata_r   <= 8'h00;
            dout_r    <= 1'b0;
            oe_n_r    <= 1'b1;
            wr_r      <= 1'b0;
            step_r    <= 1'b0;
            load_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            sh_r      <= sh_nxt;
            bitcnt_r  <= bitcnt_nxt;
            rw_r      <= rw_nxt;
            len_r     <= len_nxt;
            bytecnt_r <= bytecnt_nxt;
            addr_r    <= addr_nxt;
            tx_r      <= tx_nxt;
            wdata_r   <= wdata_nxt;
            dout_r    <= dout_nxt;
            oe_n_r    <= oe_n_nxt;
            wr_r      <= wr_nxt;
            step_r    <= step_nxt;
            load_r    <= load_nxt;
        end
    end

    assign sdio_out  = dout_r;
    assign sdio_oe_n = oe_n_r;
    assign wr_stb    = wr_r;
    assign acc_addr  = addr_r;
    assign wr_data   = wdata_r;
endmodule

// *** tb/qrcfg_regs_properties.sv ***
module qrcfg_chk (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // serial pins
    input wire logic       sclk,
    input wire logic       port_select_n,
    input wire logic       sdio_in,
    input wire logic       sdio_out,
    input wire logic       sdio_oe_n,
    // power pin and controls
    input wire logic       pdwn_pin,
    input wire logic [3:0] chan_powerdown,
    input wire logic [3:0] chan_standby,
    input wire logic [3:0] chan_shuffle_en,
    input wire logic       out_port_en_ab,
    input wire logic       out_port_en_cd,
    input wire logic       conv_clk_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // power decode, pin override and reset defaults
    chk_modes_excl: assert property (
        (chan_powerdown & chan_standby) == 4'h0)
        else $error("channel in two power modes");
    chk_pin_forces: assert property (
        pdwn_pin [*4] |-> (chan_powerdown | chan_standby) == 4'hf)
        else $error("power-down pin did not force all channels");
    chk_reset_power: assert property (
        $rose(rst_n) && !pdwn_pin |-> {chan_powerdown, chan_standby} == 8'h00)
        else $error("channels not in normal mode after reset");
    chk_reset_dflt: assert property (
        $rose(rst_n) |-> chan_shuffle_en == 4'hf && out_port_en_ab
            && out_port_en_cd)
        else $error("shuffle or output enables off after reset");
    // divided clock never stalls, longest ratio plus phase shift
    chk_clk_gap: assert property (
        conv_clk_en |-> ##[1:16] conv_clk_en)
        else $error("divided clock pulse missing");
    // data line driven only inside a frame
    chk_oe_idle: assert property (
        port_select_n [*5] |-> sdio_oe_n)
        else $error("data line driven outside a frame");
    chk_oe_frame: assert property (
        !sdio_oe_n |-> !$past(port_select_n, 5))
        else $error("data line driven without a select");
    // settings move only through a write inside a frame
    chk_shuffle_frame: assert property (
        $changed(chan_shuffle_en) |-> !$past(port_select_n, 3))
        else $error("shuffle changed outside a frame");
    chk_outen_frame: assert property (
        $changed(out_port_en_ab) || $changed(out_port_en_cd)
            |-> !$past(port_select_n, 3))
        else $error("output enable changed outside a frame");

    // main scenarios
    cov_read: cover property (!sdio_oe_n);
    cov_stby: cover property (pdwn_pin ##5 chan_standby == 4'hf);
    cov_div: cover property (conv_clk_en ##1 !conv_clk_en [*7]);
endmodule

bind qrcfg_regs qrcfg_chk u_chk (
    .clk, .rst_n, .sclk, .port_select_n, .sdio_in, .sdio_out,
    .sdio_oe_n, .pdwn_pin, .chan_powerdown, .chan_standby,
    .chan_shuffle_en, .out_port_en_ab, .out_port_en_cd, .conv_clk_en
);

// *** tb/qrcfg_host.sv ***
module qrcfg_host (
    // clock
    input wire logic clk,
    // serial pins
    output logic     sclk,
    output logic     port_select_n,
    output logic     sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv;
    logic dq;
    logic lsb;  // host bit order, set by the bench between frames

    // shared line: device, then host, else the pull-up
    assign sdio_in = !sdio_oe_n ? sdio_out : (drv ? dq : 1'b1);

    // serial clock stands low between frames
    initial begin
        sclk = 1'b0;
        port_select_n = 1'b1;
        drv = 1'b0;
        dq = 1'b0;
        lsb = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one bit: change while sclk low, sample at the rise
    task automatic shift(input logic b, output logic s);
        dq = b;
        wait_clk(10);
        sclk = 1'b1; // both phases >= 8 clk
        s = sdio_in;
        wait_clk(10);
        sclk = 1'b0;
    endtask

    // one-byte frame in the host's bit order; any offset, mapped or open
    task automatic xfer(input logic rd, input logic [12:0] a,
                        input logic [7:0] wd, output logic [7:0] q);
        logic [15:0] ins;
        logic s;
        ins = {rd, 2'h0, a};
        wait_clk(1);
        port_select_n = 1'b0;
        drv = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            shift(ins[lsb ? 15 - i : i], s);
        end
        drv = !rd; // let go before the read data phase
        for (int i = 7; i >= 0; i--) begin
            shift(wd[lsb ? 7 - i : i], s);
            q[lsb ? 7 - i : i] = s;
        end
        wait_clk(10);
        port_select_n = 1'b1;
        drv = 1'b0;
        wait_clk(6); // select high >= 4 clk between frames
    endtask
endmodule

// *** tb/qrcfg_regs_tb_top.sv ***
module qrcfg_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import qrcfg_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identity value
    localparam logic [12:0] ADR [8] = '{13'h0000, 13'h0001, 13'h0005,
        13'h0008, 13'h000b, 13'h000c, 13'h00ff, 13'h0013};
    localparam logic [7:0] DAT [8] = '{8'h18, ID_VAL, 8'hcf, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h00};
    logic       clk;
    logic       rst_n;
    logic       sclk;
    logic       port_select_n;
    logic       sdio_in;
    logic       sdio_out;
    logic       sdio_oe_n;
    logic       pdwn_pin;
    logic [3:0] chan_powerdown;
    logic [3:0] chan_standby;
    logic [3:0] chan_shuffle_en;
    logic       out_port_en_ab;
    logic       out_port_en_cd;
    logic       conv_clk_en;
    int         fails;
    int         comparisons;
    int         n;
    int         cyc = 0;
    int         pulse_at = 0;
    int         p0;

    qrcfg_regs #(.DEVICE_IDENTITY(ID_VAL)) dut (
        .clk, .rst_n, .sclk, .port_select_n, .sdio_in, .sdio_out,
        .sdio_oe_n, .pdwn_pin, .chan_powerdown, .chan_standby,
        .chan_shuffle_en, .out_port_en_ab, .out_port_en_cd, .conv_clk_en
    );
    qrcfg_host host (
        .clk, .sclk, .port_select_n, .sdio_in, .sdio_out, .sdio_oe_n
    );

    // 40 mhz
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // cycle stamp of the latest divided clock pulse, for the phase test
    always @(negedge clk) begin
        cyc++;
        if (conv_clk_en === 1'b1) begin
            pulse_at = cyc;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(1'b0, a, d, q);
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] q;
        host.xfer(1'b1, a, 8'h00, q);
        check(q, exp);
    endtask

    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // cycles between divided clock pulses, bounded
    task automatic gap(output int c);
        for (int k = 0; k < 40 && conv_clk_en !== 1'b1; k++) host.wait_clk(1);
        c = 0;
        do begin
            host.wait_clk(1);
            c++;
        end while (conv_clk_en !== 1'b1 && c < 40);
        if (c >= 40) begin
            fails++;
            summarize();
        end
    endtask

    initial begin
        rst_n = 1'b0;
        pdwn_pin = 1'b0;
        fails = 0;
        comparisons = 0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        host.wait_clk(6);
        // defaults of every mapped place and one open address
        for (int i = 0; i < 8; i++) begin
            rd_chk(ADR[i], DAT[i]);
        end
        wr(13'h0001, 8'h00);
        rd_chk(13'h0001, ID_VAL);
        // port config locked while a channel is unselected
        wr(13'h0005, 8'hc1);
        wr(13'h0000, 8'h24);
        rd_chk(13'h0005, 8'hc1);
        // shadowed power code waits for the commit
        wr(13'h0005, 8'hc2);
        wr(13'h0008, 8'h01);
        rd_chk(13'h0008, 8'h01);
        check({4'h0, chan_powerdown}, 8'h00);
        wr(13'h00ff, 8'h01);
        check({4'h0, chan_powerdown}, 8'h02);
        rd_chk(13'h00ff, 8'h00);
        wr(13'h0005, 8'hcc);
        wr(13'h0008, 8'h02);
        wr(13'h00ff, 8'h01);
        check({4'h0, chan_standby}, 8'h0c);
        // pin action: standby first, then full power-down
        wr(13'h0005, 8'hcf);
        for (int f = 1; f >= 0; f--) begin
            wr(13'h0008, {2'h0, f[0], 5'h00});
            wr(13'h00ff, 8'h01);
            pdwn_pin = 1'b1;
            host.wait_clk(5);
            check({4'h0, chan_standby}, f[0] ? 8'h0f : 8'h00);
            check({4'h0, chan_powerdown}, f[0] ? 8'h00 : 8'h0f);
            pdwn_pin = 1'b0;
            host.wait_clk(5);
        end
        check({chan_powerdown, chan_standby}, 8'h00);
        // shuffle off on a; multi-channel read returns a
        wr(13'h0005, 8'hc1);
        wr(13'h000c, 8'h00);
        wr(13'h00ff, 8'h01);
        check({4'h0, chan_shuffle_en}, 8'h0e);
        wr(13'h0005, 8'h4f);
        rd_chk(13'h000c, 8'h00);
        check({6'h0, out_port_en_cd, out_port_en_ab}, 8'h01);
        // lsb-first order through the mirrored bits, then back
        wr(13'h0000, 8'h42);
        host.lsb = 1'b1;
        rd_chk(13'h0005, 8'h4f);
        rd_chk(13'h0000, 8'h5a);
        wr(13'h0000, 8'h18);
        host.lsb = 1'b0;
        rd_chk(13'h0000, 8'h18);
        // every ratio, with a one-cycle phase held
        for (int r = 0; r < 8; r++) begin
            wr(13'h000b, 8'(r) | 8'h08);
            wr(13'h00ff, 8'h01);
            gap(n);
            check(n[7:0], 8'(r + 1));
        end
        rd_chk(13'h000b, 8'h0f);
        // phase 1 to 4 at divide by 8 moves the pulses by three cycles
        host.wait_clk(1);
        p0 = pulse_at;
        wr(13'h000b, 8'h27);
        wr(13'h00ff, 8'h01);
        check(8'((pulse_at - p0) % 8), 8'h03);
        // soft reset with all channels selected
        wr(13'h0000, 8'h24);
        rd_chk(13'h000c, 8'h01);
        rd_chk(13'h0005, 8'hcf);
        rd_chk(13'h0000, 8'h18);
        summarize();
    end
endmodule
